//--- nch_ctrl.sv
// Purpose: Host sequencer driving a small-page NAND flash for copy-back, erase,
//          status, ID, reset and block-lock commands, ordered over classic Wishbone
// Assumes: x8 part, page address A9..A24 held in 16 bits, one clock
// Notes: Pin inputs pass two flip-flops; all outputs come from flip-flops
//
// The implementer's own choices: the address map and the Wishbone slave port.
`include "nch_defines.svh"

module nch_ctrl (
   // Clock and reset
   input wire logic CLK,
   input wire logic SRST,
   input wire logic CLK_EN,
   // Wishbone slave, plus the debug state output
   input wire logic CYC_I,
   input wire logic STB_I,
   input wire logic WE_I,
   input wire logic [7:0] ADR_I,
   input wire logic [3:0] SEL_I,
   input wire logic [31:0] DAT_I,
   output nch_pkg::nch_st_e DBG_STATE,
   output logic [31:0] DAT_O,
   output logic ACK_O,
   // Flash pins
   output nch_pkg::nch_pin_s NAND_O,
   input wire logic [7:0] IO_I,
   input wire logic RB
);
   import nch_pkg::*;

   nch_state_s r;
   nch_state_s n;
   nch_item_s it;
   logic acc;
   logic launch;
   logic refuse;
   nch_op_e req_op;

   function automatic nch_item_s mk(input nch_kind_e k, input logic [7:0] d);
      nch_item_s x;
      x.kind = k;
      x.data = d;
      return x;
   endfunction

   // Step list per operation
   function automatic nch_item_s item_of(input nch_op_e op, input logic [3:0] i,
                                         input logic [15:0] a, input logic [15:0] b);
      nch_item_s x;
      logic [15:0] ab;
      logic [15:0] bb;
      x = mk(K_END, 8'h00);
      // erase mask - A9 to A13 sent as zero
      ab = {a[15:`NCH_BLK_LSB], 5'h00};
      bb = {b[15:`NCH_BLK_LSB], 5'h00};
      // no page program - copied pages left alone
      unique case (op)
         // copy-back - read, ready, then 8Ah
         OP_COPYBACK: begin
            unique case (i)
               4'h0: x = mk(K_CMD, `NCH_C_MAIN_AREA_READ_MODE);
               4'h1: x = mk(K_ADDR, 8'h00);
               4'h2: x = mk(K_ADDR, a[7:0]);
               4'h3: x = mk(K_ADDR, a[15:8]);
               4'h4: x = mk(K_WAIT, 8'h00);
               4'h5: x = mk(K_CMD, `NCH_C_COPYBACK);
               4'h6: x = mk(K_ADDR, 8'h00);
               4'h7: x = mk(K_ADDR, b[7:0]);
               4'h8: x = mk(K_ADDR, b[15:8]);
               4'h9: x = mk(K_WAIT, 8'h00);
               4'hA: x = mk(K_CMD, `NCH_C_STATUS);
               4'hB: x = mk(K_READ, 8'h00);
               default: x = mk(K_END, 8'h00);
            endcase
         end
         // erase - setup, two addresses, confirm
         OP_ERASE: begin
            unique case (i)
               4'h0: x = mk(K_CMD, `NCH_C_ERASE_SETUP);
               4'h1: x = mk(K_ADDR, ab[7:0]);
               4'h2: x = mk(K_ADDR, ab[15:8]);
               4'h3: x = mk(K_CMD, `NCH_C_ERASE_CONF);
               4'h4: x = mk(K_WAIT, 8'h00);
               4'h5: x = mk(K_CMD, `NCH_C_STATUS);
               4'h6: x = mk(K_READ, 8'h00);
               default: x = mk(K_END, 8'h00);
            endcase
         end
         // status mode - command always reissued
         OP_STATUS: begin
            if (i == 4'h0) begin
               x = mk(K_CMD, `NCH_C_STATUS);
            end else if (i == 4'h1) begin
               x = mk(K_READ, 8'h00);
            end
         end
         // ID read - 90h, 00h, two reads
         OP_ID: begin
            unique case (i)
               4'h0: x = mk(K_CMD, `NCH_C_ID);
               4'h1: x = mk(K_ADDR, 8'h00);
               4'h2: x = mk(K_READ, 8'h00);
               4'h3: x = mk(K_READ, 8'h00);
               default: x = mk(K_END, 8'h00);
            endcase
         end
         // reset busy - wait for release
         OP_RESET: begin
            if (i == 4'h0) begin
               x = mk(K_CMD, `NCH_C_RESET);
            end else if (i == 4'h1) begin
               x = mk(K_WAIT, 8'h00);
            end
         end
         OP_LOCK: begin
            if (i == 4'h0) begin
               x = mk(K_CMD, `NCH_C_LOCK);
            end
         end
         OP_LOCK_TIGHT: begin
            if (i == 4'h0) begin
               x = mk(K_CMD, `NCH_C_LOCK_TIGHT);
            end
         end
         // unlock range - start then end
         OP_UNLOCK: begin
            unique case (i)
               4'h0: x = mk(K_CMD, `NCH_C_UNLOCK1);
               4'h1: x = mk(K_ADDR, ab[7:0]);
               4'h2: x = mk(K_ADDR, ab[15:8]);
               4'h3: x = mk(K_CMD, `NCH_C_UNLOCK2);
               4'h4: x = mk(K_ADDR, bb[7:0]);
               4'h5: x = mk(K_ADDR, bb[15:8]);
               default: x = mk(K_END, 8'h00);
            endcase
         end
      endcase
      return x;
   endfunction

   assign it = item_of(r.op, r.idx, r.addr_a, r.addr_b);
   assign acc = CYC_I && STB_I && !r.ack;
   assign launch = acc && WE_I && SEL_I[0] && (ADR_I == `NCH_REG_CMD) && !r.busy;
   assign req_op = nch_op_e'(DAT_I[2:0]);

   always_comb begin
      refuse = 1'b0;
      // plane check - copy-back within one plane
      if (req_op == OP_COPYBACK) begin
         refuse = r.addr_a[`NCH_PLANE_BIT] != r.addr_b[`NCH_PLANE_BIT];
      end
      // unlock order - start not above end
      if (req_op == OP_UNLOCK) begin
         refuse = r.addr_a[15:`NCH_BLK_LSB] > r.addr_b[15:`NCH_BLK_LSB];
      end
      // lock gating - needs select pin high
      if (req_op == OP_LOCK || req_op == OP_LOCK_TIGHT || req_op == OP_UNLOCK) begin
         refuse = refuse || !r.pin.lock_feature_select;
      end
   end

   always_comb begin
      n = r;
      n.rb_sy = {r.rb_sy[0], RB};
      n.io_s1 = IO_I;
      n.io_s2 = r.io_s1;
      // Wishbone: one-cycle ack, dropped the cycle after
      n.ack = acc;
      n.dat = 32'h0000_0000;
      if (acc && !WE_I) begin
         unique case (ADR_I)
            `NCH_REG_CMD: n.dat = {29'h0000_0000, r.op};
            `NCH_REG_ADDR_A: n.dat = {16'h0000, r.addr_a};
            `NCH_REG_ADDR_B: n.dat = {16'h0000, r.addr_b};
            `NCH_REG_CFG: n.dat = {30'h0000_0000, r.pin.lock_feature_select, r.pin.wp_n};
            `NCH_REG_STAT: n.dat = {16'h0000, r.status, 5'h00, r.rb_sy[1], r.refused, r.busy};
            `NCH_REG_ID: n.dat = {16'h0000, r.id1, r.id0};
            default: n.dat = 32'h0000_0000;
         endcase
      end
      if (acc && WE_I && SEL_I[0] && !r.busy) begin
         if (ADR_I == `NCH_REG_ADDR_A) begin
            n.addr_a = {DAT_I[15:8], DAT_I[7:0]};
         end
         if (ADR_I == `NCH_REG_ADDR_B) begin
            n.addr_b = DAT_I[15:0];
         end
         // write protect - software pulses WP low
         if (ADR_I == `NCH_REG_CFG) begin
            n.pin.wp_n = DAT_I[0];
            n.pin.lock_feature_select = DAT_I[1];
         end
      end
      if (launch) begin
         n.refused = refuse;
         if (!refuse) begin
            n.op = req_op;
            n.busy = 1'b1;
            n.idx = 4'h0;
            n.rdi = 2'h0;
            n.st = ST_FETCH;
            n.pin.ce_n = 1'b0;
         end
      end
      unique case (r.st)
         ST_IDLE: begin
         end
         ST_FETCH: begin
            n.ph = 2'h0;
            n.pin.cle = 1'b0;
            n.pin.ale = 1'b0;
            n.pin.io_oe_n = 1'b1;
            unique case (it.kind)
               K_END: begin
                  n.st = ST_IDLE;
                  n.busy = 1'b0;
                  n.pin.ce_n = 1'b1;
               end
               K_CMD, K_ADDR: begin
                  // latch select - CLE for command, ALE for address
                  n.pin.cle = it.kind == K_CMD;
                  n.pin.ale = it.kind == K_ADDR;
                  n.pin.io = it.data;
                  n.pin.io_oe_n = 1'b0;
                  n.cnt = 8'(`NCH_SETUP_CYC - 1);
                  n.st = ST_STROBE;
               end
               K_WAIT: begin
                  n.cnt = 8'(`NCH_WB_CYC - 1);
                  n.st = ST_TWB;
               end
               K_READ: begin
                  n.pin.read_strobe_low = 1'b0;
                  n.cnt = 8'(`NCH_REA_CYC - 1);
                  n.st = ST_READ;
               end
               default: n.st = ST_IDLE;
            endcase
         end
         ST_STROBE: begin
            if (r.cnt != 8'h00) begin
               n.cnt = r.cnt - 8'h01;
            end else if (r.ph == 2'h0) begin
               n.pin.we_n = 1'b0;
               n.ph = 2'h1;
               n.cnt = 8'(`NCH_WP_CYC - 1);
            end else if (r.ph == 2'h1) begin
               // confirm edge - device starts on this rise
               n.pin.we_n = 1'b1;
               n.ph = 2'h2;
               n.cnt = 8'(`NCH_WH_CYC - 1);
            end else begin
               n.idx = r.idx + 4'h1;
               n.st = ST_FETCH;
            end
         end
         ST_TWB: begin
            if (r.cnt != 8'h00) begin
               n.cnt = r.cnt - 8'h01;
            end else begin
               n.st = ST_WAIT;
            end
         end
         ST_WAIT: begin
            if (r.rb_sy[1]) begin
               n.idx = r.idx + 4'h1;
               n.st = ST_FETCH;
            end
         end
         ST_READ: begin
            if (r.cnt != 8'h00) begin
               n.cnt = r.cnt - 8'h01;
            end else if (r.ph == 2'h0) begin
               // status or ID sample - one read cycle
               if (r.op == OP_ID) begin
                  if (r.rdi == 2'h0) begin
                     n.id0 = r.io_s2;
                  end else begin
                     n.id1 = r.io_s2;
                  end
               end else begin
                  n.status = r.io_s2;
               end
               n.rdi = r.rdi + 2'h1;
               n.pin.read_strobe_low = 1'b1;
               n.ph = 2'h1;
               n.cnt = 8'(`NCH_REH_CYC - 1);
            end else begin
               n.idx = r.idx + 4'h1;
               n.st = ST_FETCH;
            end
         end
         default: n.st = ST_IDLE;
      endcase
   end

   always_ff @(posedge CLK) begin
      if (SRST) begin
         r <= '0;
         r.st <= ST_IDLE;
         r.status <= `NCH_RST_STATUS;
         r.pin.ce_n <= 1'b1;
         r.pin.we_n <= 1'b1;
         r.pin.read_strobe_low <= 1'b1;
         r.pin.io_oe_n <= 1'b1;
         r.pin.wp_n <= 1'(`NCH_RST_CFG & 2'h1);
      end else if (CLK_EN) begin
         r <= n;
      end
   end

   assign NAND_O = r.pin;
   assign ACK_O = r.ack;
   assign DAT_O = r.dat;
   assign DBG_STATE = r.st;

   // Checks
   a_ack_single: assert property (@(posedge CLK) disable iff (SRST)
      ACK_O |=> !ACK_O || !CLK_EN) else $error("ack held longer than one cycle");
   a_latch_excl: assert property (@(posedge CLK) disable iff (SRST)
      !(NAND_O.cle && NAND_O.ale)) else $error("CLE and ALE both high");
   a_strobe_data: assert property (@(posedge CLK) disable iff (SRST)
      (!NAND_O.we_n) |-> !NAND_O.io_oe_n && (NAND_O.cle || NAND_O.ale))
      else $error("write strobe low without driven byte");
   a_we_width: assert property (@(posedge CLK) disable iff (SRST || !CLK_EN)
      $fell(NAND_O.we_n) |-> !NAND_O.we_n [*3]) else $error("write strobe too short");
   a_plane_same: assert property (@(posedge CLK) disable iff (SRST)
      (r.busy && r.op == OP_COPYBACK) |-> r.addr_a[5] == r.addr_b[5])
      else $error("copy-back across planes");
   a_erase_mask: assert property (@(posedge CLK) disable iff (SRST)
      (r.op == OP_ERASE && NAND_O.ale && r.idx == 4'h1) |-> NAND_O.io[4:0] == 5'h00)
      else $error("erase address low bits not zero");
   a_lock_sel: assert property (@(posedge CLK) disable iff (SRST)
      (r.busy && (r.op == OP_LOCK || r.op == OP_LOCK_TIGHT || r.op == OP_UNLOCK))
      |-> NAND_O.lock_feature_select) else $error("lock command without select");
   a_unlock_order: assert property (@(posedge CLK) disable iff (SRST)
      (r.busy && r.op == OP_UNLOCK) |-> r.addr_a[15:5] <= r.addr_b[15:5])
      else $error("unlock range descending");
   a_ready_wait: assert property (@(posedge CLK) disable iff (SRST || !CLK_EN)
      (r.st == ST_WAIT && r.rb_sy[1]) |=> r.st == ST_FETCH)
      else $error("ready not followed");
   a_idle_ce: assert property (@(posedge CLK) disable iff (SRST)
      (r.st == ST_IDLE) |-> NAND_O.ce_n) else $error("chip enable low while idle");

   c_copyback: cover property (@(posedge CLK) r.op == OP_COPYBACK && $fell(r.busy));
   c_erase: cover property (@(posedge CLK) r.op == OP_ERASE && $fell(r.busy));
   c_id: cover property (@(posedge CLK) r.op == OP_ID && r.rdi == 2'h2);
   c_refused: cover property (@(posedge CLK) launch && refuse);
endmodule

//--- nch_defines.svh
// Purpose: Constants for the NAND copy-back / erase / status / lock host sequencer
// Assumes: 100 MHz CLK, x8 small-page NAND on the far side
// Notes: Times in ns, cycle counts derived from them
`ifndef NCH_DEFINES_SVH
`define NCH_DEFINES_SVH

// Register word offsets (byte addresses)
`define NCH_REG_CMD 8'h00
`define NCH_REG_ADDR_A 8'h04
`define NCH_REG_ADDR_B 8'h08
`define NCH_REG_CFG 8'h0C
`define NCH_REG_STAT 8'h10
`define NCH_REG_ID 8'h14

// Reset values
`define NCH_RST_CFG 2'h0
`define NCH_RST_STATUS 8'hC0

// Device command bytes
`define NCH_C_MAIN_AREA_READ_MODE 8'h00
`define NCH_C_COPYBACK 8'h8A
`define NCH_C_ERASE_SETUP 8'h60
`define NCH_C_ERASE_CONF 8'hD0
`define NCH_C_STATUS 8'h70
`define NCH_C_ID 8'h90
`define NCH_C_RESET 8'hFF
`define NCH_C_LOCK 8'h2A
`define NCH_C_LOCK_TIGHT 8'h2C
`define NCH_C_UNLOCK1 8'h23
`define NCH_C_UNLOCK2 8'h24

// Field positions
`define NCH_PLANE_BIT 5
`define NCH_BLK_LSB 5

// Timing, ns and cycles (least times round up)
`define NCH_CLK_NS 10
`define NCH_T_SETUP_NS 20
`define NCH_T_WP_NS 25
`define NCH_T_WH_NS 15
`define NCH_T_WB_NS 100
`define NCH_T_REA_NS 35
`define NCH_T_REH_NS 15
`define NCH_CYC(ns) (((ns) + `NCH_CLK_NS - 1) / `NCH_CLK_NS)
`define NCH_SETUP_CYC `NCH_CYC(`NCH_T_SETUP_NS)
`define NCH_WP_CYC `NCH_CYC(`NCH_T_WP_NS)
`define NCH_WH_CYC `NCH_CYC(`NCH_T_WH_NS)
`define NCH_WB_CYC `NCH_CYC(`NCH_T_WB_NS)
// Two extra cycles cover the input synchroniser
`define NCH_REA_CYC (`NCH_CYC(`NCH_T_REA_NS) + 2)
`define NCH_REH_CYC `NCH_CYC(`NCH_T_REH_NS)

`endif

//--- nch_pkg.sv
// Purpose: Types for the NAND host sequencer
// Assumes: nch_defines.svh holds the numbers
// Notes: None
package nch_pkg;
   typedef enum logic [2:0] {
      OP_COPYBACK, OP_ERASE, OP_STATUS, OP_ID, OP_RESET, OP_LOCK, OP_LOCK_TIGHT, OP_UNLOCK
   } nch_op_e;
   typedef enum logic [2:0] {ST_IDLE, ST_FETCH, ST_STROBE, ST_TWB, ST_WAIT, ST_READ} nch_st_e;
   typedef enum logic [2:0] {K_END, K_CMD, K_ADDR, K_WAIT, K_READ} nch_kind_e;
   typedef struct packed {
      nch_kind_e kind;
      logic [7:0] data;
   } nch_item_s;
   // Pins driven toward the flash
   typedef struct packed {
      logic ce_n;
      logic cle;
      logic ale;
      logic we_n;
      logic read_strobe_low;
      logic wp_n;
      logic lock_feature_select;
      logic io_oe_n;
      logic [7:0] io;
   } nch_pin_s;
   typedef struct packed {
      nch_st_e st;
      nch_op_e op;
      logic [3:0] idx;
      logic [1:0] ph;
      logic [7:0] cnt;
      logic [1:0] rdi;
      logic [15:0] addr_a;
      logic [15:0] addr_b;
      logic busy;
      logic refused;
      logic [7:0] status;
      logic [7:0] id0;
      logic [7:0] id1;
      logic [1:0] rb_sy;
      logic [7:0] io_s1;
      logic [7:0] io_s2;
      nch_pin_s pin;
      logic ack;
      logic [31:0] dat;
   } nch_state_s;
endpackage

//--- nch_flash_model.sv
// Purpose: Behavioural x8 NAND flash facing the host sequencer pins
// Assumes: Strobe edges drive it; ready/busy is pulled up when released
// Notes: Busy times are short stand-ins; identity codes are arbitrary values
module nch_flash_model #(
   parameter logic [7:0] MAKER_CODE = 8'h5A, // Arbitrary value
   parameter logic [7:0] DEVICE_CODE = 8'hA6, // Arbitrary value
   parameter int BUSY_NS = 2000,
   parameter int RST_NS = 500
) (
   // Host pins
   input nch_pkg::nch_pin_s pin,
   // Device pins
   output logic [7:0] io_o,
   output logic rb
);
   timeunit 1ns;
   timeprecision 100ps;
   import nch_pkg::*;
   typedef enum logic [1:0] {M_READ, M_IDLE, M_STAT, M_IDENT} nch_mode_e;
   nch_mode_e mode = M_READ;
   logic [7:0] cmd = 8'h00, prev = 8'h00, out_q = 8'h00, held = 8'h00;
   logic [7:0] ad [3] = '{8'h00, 8'h00, 8'h00};
   logic [10:0] ulo = 11'h7FF, uhi = 11'h000, ustart = 11'h000;
   logic fail = 1'b0, in_rst = 1'b0, tight = 1'b0;
   int busy_ns = 0, rdn = 0, acnt = 0;
   wire ready = busy_ns == 0;
   wire drv = !pin.ce_n && !pin.read_strobe_low;
   wire [7:0] stat = {pin.wp_n, ready, 5'h00, fail};
   function automatic logic [10:0] blk();
      return {ad[2], ad[1][7:5]};
   endfunction
   function automatic logic locked();
      return pin.lock_feature_select && !(blk() >= ulo && blk() <= uhi);
   endfunction
   // drive while both strobes low, scramble once released
   assign io_o = drv ? (mode == M_STAT ? stat : out_q) : ~held;
   // open drain, pulled up when ready
   assign rb = ready;
   always #10 begin
      if (busy_ns > 0) busy_ns -= 10;
   end
   always @(negedge pin.read_strobe_low) begin
      if (!pin.ce_n) begin
         if (mode == M_IDENT) out_q = rdn == 0 ? MAKER_CODE : DEVICE_CODE;
         rdn++;
         held = mode == M_STAT ? stat : out_q;
      end
   end
   // latch on strobe rise; only 70h and FFh while busy
   always @(posedge pin.we_n) begin
      if (!pin.ce_n && pin.cle && (ready || pin.io == 8'h70 || pin.io == 8'hFF)) begin
         prev = cmd;
         cmd = pin.io;
         acnt = 0;
         if (cmd != 8'hFF) in_rst = 1'b0;
         case (cmd)
            8'hFF: if (!in_rst) begin
               in_rst = 1'b1;
               fail = 1'b0;
               busy_ns = RST_NS;
               mode = M_IDLE;
            end
            8'h70: mode = M_STAT;
            8'h90: begin
               mode = M_IDENT;
               rdn = 0;
            end
            8'hD0: if (prev == 8'h60) begin
               fail = locked() || !pin.wp_n;
               busy_ns = BUSY_NS;
            end
            8'h2A: if (pin.lock_feature_select) begin
               ulo = 11'h7FF;
               uhi = 11'h000;
            end
            8'h2C: tight = tight | pin.lock_feature_select;
            8'h00: mode = M_READ;
            default: mode = M_IDLE;
         endcase
      end else if (!pin.ce_n && pin.ale && ready) begin
         ad[0] = ad[1];
         ad[1] = ad[2];
         ad[2] = pin.io;
         acnt++;
         // page to buffer, buffer to destination
         if (acnt == 3 && (cmd == 8'h00 || cmd == 8'h8A)) begin
            fail = cmd == 8'h8A && (locked() || !pin.wp_n);
            busy_ns = BUSY_NS;
         end
         // one ascending range, refused when tight
         if (acnt == 2 && cmd == 8'h23) ustart = blk();
         if (acnt == 2 && cmd == 8'h24 && pin.lock_feature_select && !tight) begin
            ulo = ustart;
            uhi = blk();
         end
      end
   end
   always @(negedge pin.wp_n) begin
      tight = 1'b0;
      ulo = 11'h7FF;
      uhi = 11'h000;
   end
endmodule

//--- nch_ctrl_bench.sv
// Purpose: Self-checking bench for the NAND host sequencer over Wishbone
// Assumes: Flash model on the pins; every block starts locked
// Notes: Expected status bytes follow the flash status layout
`include "nch_defines.svh"
module nch_ctrl_bench;
   timeunit 1ns;
   timeprecision 100ps;
   import nch_pkg::*;
   localparam logic [7:0] MAKER = 8'h5A; // Arbitrary value
   localparam logic [7:0] DEVICE = 8'hA6; // Arbitrary value
   logic clk = 1'b0, srst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, ack_o, rb;
   logic [7:0] adr = 8'h00, io_i;
   logic [31:0] wdat = 32'h0000_0000, rd, dat_o;
   nch_pin_s pin;
   nch_st_e dbg;
   int num_errors = 0, tests_run = 0;
   nch_ctrl uut (
      .CLK(clk), .SRST(srst), .CLK_EN(1'b1), .CYC_I(cyc), .STB_I(stb), .WE_I(we), .ADR_I(adr),
      .SEL_I(4'hF), .DAT_I(wdat), .DBG_STATE(dbg), .DAT_O(dat_o), .ACK_O(ack_o), .NAND_O(pin),
      .IO_I(io_i), .RB(rb)
   );
   nch_flash_model #(.MAKER_CODE(MAKER), .DEVICE_CODE(DEVICE)) flash (
      .pin(pin), .io_o(io_i), .rb(rb)
   );
   initial begin
      forever #5 clk = ~clk;
   end
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      // Only the watchdog ends a wait for the answer
      do begin
         @(posedge clk);
      end while (ack_o !== 1'b1);
      rd = dat_o;
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         num_errors++;
         $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wait_idle();
      do begin
         wb(1'b0, `NCH_REG_STAT, 32'h0000_0000);
      end while (rd[0] !== 1'b0);
   endtask
   // Bit 8 of ex asks for a refusal, else bits 7:0 are the status byte
   task automatic op(input logic [2:0] code, input logic [15:0] a, input logic [15:0] b,
                     input logic [8:0] ex);
      wb(1'b1, `NCH_REG_ADDR_A, {16'h0000, a});
      wb(1'b1, `NCH_REG_ADDR_B, {16'h0000, b});
      wb(1'b1, `NCH_REG_CMD, 32'(code));
      wait_idle();
      if (ex[8]) chk(32'(rd[1]), 32'h0000_0001);
      else chk(32'(rd[15:8]), 32'(ex[7:0]));
   endtask
   task automatic close_out();
      $display("Comparisons %0d, mismatches %0d", tests_run, num_errors);
      if (num_errors == 0 && tests_run > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   initial begin
      #900_000;
      num_errors++;
      close_out();
   end
   initial begin
      repeat (3) @(posedge clk);
      srst <= 1'b0;
      wb(1'b0, `NCH_REG_STAT, 32'h0000_0000);
      chk(32'(rd[15:8]), 32'h0000_00C0);
      wb(1'b0, `NCH_REG_CFG, 32'h0000_0000);
      chk(rd, 32'h0000_0000);
      wb(1'b1, 8'h1C, 32'hFFFF_FFFF);
      wb(1'b0, 8'h1C, 32'h0000_0000);
      chk(rd, 32'h0000_0000);
      $display("Test reset values done");
      wb(1'b1, `NCH_REG_CFG, 32'h0000_0001);
      op(3'h2, 16'h0000, 16'h0000, 9'h0C0);
      op(3'h3, 16'h0000, 16'h0000, 9'h0C0);
      wb(1'b0, `NCH_REG_ID, 32'h0000_0000);
      chk(rd, {16'h0000, DEVICE, MAKER});
      op(3'h1, 16'h001F, 16'h0000, 9'h0C0);
      op(3'h0, 16'h0020, 16'h0060, 9'h0C0);
      op(3'h0, 16'h0000, 16'h0020, 9'h100);
      op(3'h5, 16'h0000, 16'h0000, 9'h100);
      op(3'h4, 16'h0000, 16'h0000, 9'h0C0);
      op(3'h4, 16'h0000, 16'h0000, 9'h0C0);
      $display("Test plain part done");
      wb(1'b1, `NCH_REG_CFG, 32'h0000_0003);
      op(3'h1, 16'h0060, 16'h0000, 9'h0C1);
      op(3'h7, 16'h0040, 16'h0080, 9'h0C1);
      op(3'h1, 16'h007F, 16'h0000, 9'h0C0);
      op(3'h1, 16'h00A0, 16'h0000, 9'h0C1);
      op(3'h7, 16'h0080, 16'h0040, 9'h100);
      op(3'h6, 16'h0000, 16'h0000, 9'h0C1);
      op(3'h7, 16'h0000, 16'h07E0, 9'h0C1);
      op(3'h1, 16'h0020, 16'h0000, 9'h0C1);
      wb(1'b1, `NCH_REG_CFG, 32'h0000_0002);
      op(3'h1, 16'h0060, 16'h0000, 9'h041);
      wb(1'b1, `NCH_REG_CFG, 32'h0000_0003);
      op(3'h7, 16'h0020, 16'h0020, 9'h041);
      op(3'h1, 16'h0020, 16'h0000, 9'h0C0);
      op(3'h5, 16'h0000, 16'h0000, 9'h0C0);
      op(3'h1, 16'h0020, 16'h0000, 9'h0C1);
      op(3'h4, 16'h0000, 16'h0000, 9'h0C1);
      op(3'h2, 16'h0000, 16'h0000, 9'h0C0);
      $display("Test block lock done");
      wb(1'b1, `NCH_REG_CMD, 32'h0000_0001);
      wb(1'b1, `NCH_REG_CMD, 32'h0000_0002);
      wb(1'b0, `NCH_REG_STAT, 32'h0000_0000);
      chk(32'(rd[1:0]), 32'h0000_0001);
      wb(1'b0, `NCH_REG_CMD, 32'h0000_0000);
      chk(rd, 32'h0000_0001);
      wait_idle();
      chk(32'(rd[2:0]), 32'h0000_0004);
      chk(32'(rd[15:8]), 32'h0000_00C1);
      chk(32'(dbg), 32'(ST_IDLE));
      $display("Test busy refusal done");
      close_out();
   end
endmodule
